//--- pkg/eal_params.svh
// Constants for the effective address and loop unit
`ifndef EAL_PARAMS_SVH
`define EAL_PARAMS_SVH
`define EAL_NREG       17
`define EAL_ALIAS_REG  4'hF
`define EAL_USP_IDX    5'h0F
`define EAL_SSP_IDX    5'h10
`define EAL_REG_RST    32'h00000000
`define EAL_PC_STEP    32'h00000002
`define EAL_LOOP_LEN   32'h00000004
`define EAL_LOOP_END   32'hFFFFFFFF
`define EAL_STEP_B     32'h00000001
`define EAL_STEP_W     32'h00000002
`define EAL_STEP_L     32'h00000004
`define EAL_QADD_MIN   8'h01
`define EAL_QADD_MAX   8'h08
`define EAL_BIT_ONE    32'h00000001
`endif

//--- pkg/eal_pkg.sv
// Types for the effective address and loop unit
package eal_pkg;
  typedef enum logic [3:0] {
    OP_EA, OP_BRANCH, OP_LOOP, OP_MRT, OP_QADD, OP_ADDRDST, OP_QMOVE, OP_MEMORY_COMPARE_POSTINC, OP_BIT
  } eal_op_type;
  typedef enum logic [3:0] {
    EA_DREG, EA_AREG, EA_IND, EA_PREDEC, EA_POSTINC, EA_DISP, EA_INDEX,
    EA_ABS_S, EA_ABS_L, EA_PC_DISP, EA_PC_INDEX, EA_IMM
  } eal_mode_type;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} eal_size_type;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_XFER = 3'b010, ST_WB = 3'b100} eal_state_type;
  typedef struct packed {
    eal_op_type   op;
    eal_mode_type mode;
    eal_size_type size;
    logic [2:0]   reg_num;
    logic [2:0]   reg2;
    logic [3:0]   idx_reg;
    logic         idx_long;
    logic         long_disp;
    logic         cond;
    logic         sup;
    logic         to_mem;
    logic [7:0]   imm8;
    logic [15:0]  mask;
    logic [15:0]  ext0;
    logic [15:0]  ext1;
    logic [31:0]  pc;
  } eal_req_type;
  typedef struct packed {
    logic [31:0] ea;
    logic [31:0] ea2;
    logic [31:0] target;
    logic [31:0] result;
    logic        taken;
    logic        fault;
    logic        illegal;
  } eal_resp_type;
  typedef struct packed {
    logic         req;
    logic         we;
    eal_size_type size;
    logic [31:0]  addr;
    logic [31:0]  wdata;
  } eal_mem_type;
endpackage

//--- sim/eal_mem_model.sv
// Memory partner serving one outstanding request of the unit
module eal_mem_model
  import eal_pkg::*;
(
  input  logic                 core_clk,
  input  logic                 rst_b,
  input  eal_pkg::eal_mem_type mem_q,
  input  logic [1:0]           lat,
  output logic                 mem_ack,
  output logic [31:0]          mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  bit [31:0]  mem [bit [31:0]];
  logic [1:0] wait_q;
  // Data bus toggles outside an ack so stale data cannot pass
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
      wait_q <= 2'h0;
    end else if (mem_q.req && !mem_ack && wait_q >= lat) begin
      mem_ack <= 1'b1;
      wait_q <= 2'h0;
      if (mem_q.we) mem[mem_q.addr] = mem_q.wdata;
      mem_rdata <= mem[mem_q.addr];
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_q <= (mem_q.req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

//--- sim/eal_unit_props.sv
// Port-level checks for the effective address and loop unit
module eal_unit_props
  import eal_pkg::*;
(
  input logic                  core_clk,
  input logic                  rst_b,
  input logic                  req_valid,
  input eal_pkg::eal_req_type  req,
  input logic                  wr_en,
  input logic [4:0]            wr_idx,
  input logic [31:0]           wr_data,
  input logic [4:0]            rd_idx,
  input logic                  mem_ack,
  input logic [31:0]           mem_rdata,
  input logic                  busy_q,
  input logic                  done_q,
  input eal_pkg::eal_resp_type resp_q,
  input eal_pkg::eal_mem_type  mem_q,
  input logic [31:0]           rd_data_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic tk;
  // Odd pc answers with a fault, so those are checked apart
  assign tk = req_valid && !busy_q && !req.pc[0];
  function automatic logic [31:0] sx16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction
  br_long_a: assert property (tk && req.op == OP_BRANCH && req.long_disp
    |=> !resp_q.taken || resp_q.target == $past(req.pc) + 32'h2 + sx16($past(req.ext0)))
    else $error("long branch target wrong");
  loop_hold_a: assert property (tk && req.op == OP_LOOP && req.cond
    |=> done_q && !resp_q.taken && resp_q.target == $past(req.pc) + 32'h4)
    else $error("loop with condition met did not fall through");
  loop_tgt_a: assert property (tk && req.op == OP_LOOP
    |=> !resp_q.taken || resp_q.target == $past(req.pc) + 32'h2 + sx16($past(req.ext0)))
    else $error("loop target wrong");
  qmove_ext_a: assert property (tk && req.op == OP_QMOVE
    |=> resp_q.result == {{24{$past(req.imm8[7])}}, $past(req.imm8)})
    else $error("quick move not sign extended");
  qadd_range_a: assert property (tk && req.op == OP_QADD
    && (req.imm8 == 8'h0 || req.imm8 > 8'h08)
    |=> done_q && resp_q.illegal) else $error("quick add range not refused");
  adst_form_a: assert property (tk && req.op == OP_ADDRDST
    && (req.mode != EA_AREG || req.size == SZ_BYTE) |=> resp_q.illegal)
    else $error("address destination form not refused");
  odd_pc_a: assert property (req_valid && !busy_q && req.pc[0] && req.op != OP_MRT
    |=> done_q && resp_q.fault) else $error("odd instruction address not faulted");
  mem_hold_a: assert property (mem_q.req && !mem_ack |=> mem_q.req && $stable(mem_q.addr))
    else $error("memory request dropped before ack");
endmodule
bind eal_unit eal_unit_props u_props (
  .core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req(req), .wr_en(wr_en),
  .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(rd_idx), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .busy_q(busy_q), .done_q(done_q), .resp_q(resp_q), .mem_q(mem_q),
  .rd_data_q(rd_data_q));

//--- sim/eal_unit_test.sv
// Self-checking bench for the effective address and loop unit
module eal_unit_test
  import eal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] sel; logic [2:0] flg; logic [31:0] val;} eal_note_type;
  logic         core_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, wr_en = 1'b0, f;
  logic [4:0]   wr_idx = 5'h0, rd_idx = 5'h0;
  logic [31:0]  wr_data = 32'h0, mem_rdata, rd_data_q, e, b;
  logic [1:0]   lat = 2'h0;
  logic         mem_ack, busy_q, done_q;
  eal_req_type  rq = '0, x;
  eal_resp_type resp_q;
  eal_mem_type  mem_q;
  eal_note_type notes[$], n;
  logic [31:0]  mir[17], fld[4];
  int           errors = 0, tests_run = 0, cyc = 0, i, a;
  eal_unit dut (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req(rq),
    .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .rd_idx(rd_idx), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .busy_q(busy_q), .done_q(done_q), .resp_q(resp_q), .mem_q(mem_q),
    .rd_data_q(rd_data_q));
  eal_mem_model u_mem (.core_clk(core_clk), .rst_b(rst_b), .mem_q(mem_q), .lat(lat),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  always #25 core_clk = ~core_clk;
  // Run needs a few hundred cycles; ceiling leaves wide margin
  always @(posedge core_clk) if (++cyc > 5000) begin
    errors++;
    results();
  end
  always @(negedge core_clk) if (done_q === 1'b1) begin
    if (notes.size() == 0) chk(32'h1, 32'h0);
    n = notes.pop_front();
    fld = '{resp_q.ea, resp_q.ea2, resp_q.target, resp_q.result};
    chk({29'h0, resp_q.taken, resp_q.fault, resp_q.illegal}, {29'h0, n.flg});
    if (n.sel < 3'h4) chk(fld[n.sel[1:0]], n.val);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (notes.size() != 0) errors++;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [31:0] s16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction
  function automatic logic [31:0] s8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction
  // Logical register 15 is the stack alias
  function automatic int ph(input logic [3:0] k, input logic sup);
    return k == 4'hF ? (sup ? 16 : 15) : int'(k);
  endfunction
  function automatic void mk(input eal_op_type op, input eal_mode_type md,
                             input eal_size_type sz, input logic [2:0] rn);
    x = '0;
    x.op = op;
    x.mode = md;
    x.size = sz;
    x.reg_num = rn;
    x.pc = $urandom & 32'hFFFFFFFE;
    x.ext0 = 16'($urandom) & 16'hFFFE;
    x.ext1 = 16'($urandom) & 16'hFFFE;
    x.imm8 = 8'($urandom) & 8'hFE;
    x.idx_reg = 4'($urandom);
    x.idx_long = 1'($urandom);
    x.sup = 1'($urandom);
  endfunction
  task automatic send(input logic [2:0] sel, input logic [31:0] val, input logic [2:0] flg);
    notes.push_back({sel, flg, val});
    @(negedge core_clk);
    req_valid = 1'b1;
    rq = x;
  endtask
  task automatic drain;
    @(negedge core_clk);
    req_valid = 1'b0;
    for (int k = 0; k < 400 && notes.size() > 0; k++) @(negedge core_clk);
  endtask
  task automatic wreg(input int k, input logic [31:0] v);
    @(negedge core_clk);
    req_valid = 1'b0;
    wr_en = 1'b1;
    wr_idx = 5'(k);
    wr_data = v;
    mir[k] = v;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask
  task automatic rchk(input int k);
    @(negedge core_clk);
    rd_idx = 5'(k);
    @(negedge core_clk);
    chk(rd_data_q, mir[k]);
  endtask
  initial begin
    void'($urandom(32'h69a9));
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    chk({29'h0, busy_q, done_q, mem_q.req}, 32'h0);
    for (i = 0; i < 17; i++) wreg(i, $urandom & 32'hFFFFFFFE);
    // Every memory mode at all three sizes, back to back, on A2 and the alias
    for (i = 0; i < 30; i++) begin
      mk(OP_EA, eal_mode_type'(4'h2 + 4'(i % 10)), eal_size_type'(i / 10), i[0] ? 3'h2 : 3'h7);
      a = ph({1'b1, x.reg_num}, x.sup);
      b = mir[a];
      e = mir[ph(x.idx_reg, x.sup)];
      if (!x.idx_long) e = s16(e[15:0]);
      case (x.mode)
        EA_PREDEC: e = b - (32'h1 << x.size);
        EA_IND, EA_POSTINC: e = b;
        EA_DISP: e = b + s16(x.ext0);
        EA_INDEX: e = b + s8(x.ext0[7:0]) + e;
        EA_ABS_S: e = s16(x.ext0);
        EA_ABS_L: e = {x.ext0, x.ext1};
        EA_PC_DISP: e = x.pc + 32'h2 + s16(x.ext0);
        EA_PC_INDEX: e = x.pc + 32'h2 + s8(x.ext0[7:0]) + e;
        EA_IMM: begin
          if (x.size == SZ_BYTE) e = {24'h0, x.ext0[7:0]};
          else if (x.size == SZ_WORD) e = {16'h0, x.ext0};
          else e = {x.ext0, x.ext1};
        end
        default: e = 32'h0;
      endcase
      f = e[0] && x.size != SZ_BYTE;
      if (!f && x.mode == EA_PREDEC) mir[a] = e;
      if (!f && x.mode == EA_POSTINC) mir[a] = b + (32'h1 << x.size);
      a = x.mode == EA_IMM ? 3 : 0;
      send(3'(a), e, {1'b0, f, 1'b0});
    end
    wreg(3, 32'h1);
    for (i = 0; i < 3; i++) begin
      mk(OP_LOOP, EA_DREG, SZ_WORD, 3'h3);
      x.cond = i == 2;
      b = mir[3] - 32'h1;
      f = !x.cond && b != 32'hFFFFFFFF;
      if (!x.cond) mir[3] = b;
      send(3'h2, f ? x.pc + 32'h2 + s16(x.ext0) : x.pc + 32'h4, {f, 2'h0});
    end
    for (i = 0; i < 17; i++) wreg(i, $urandom & 32'hFFFFFFFE);
    for (i = 0; i < 2; i++) begin
      mk(OP_MEMORY_COMPARE_POSTINC, EA_POSTINC, eal_size_type'(2 - i), 3'h1);
      x.reg2 = 3'h2;
      send(3'(i), mir[9 + i], 3'h0);
      mir[9] += 32'h1 << x.size;
      mir[10] += 32'h1 << x.size;
    end
    mk(OP_MRT, EA_POSTINC, SZ_WORD, 3'h6);
    x.mask = 16'h02A2;
    a = mir[14];
    for (i = 0; i < 16; i++) if (x.mask[i]) begin
      b = $urandom;
      u_mem.mem[a] = b;
      mir[i] = s16(b[15:0]);
      a += 2;
    end
    mir[14] = a;
    send(3'h7, 32'h0, 3'h0);
    drain();
    lat = 2'h3;
    mk(OP_MRT, EA_PREDEC, SZ_LONG, 3'h0);
    x.mask = 16'h7C00;
    x.to_mem = 1'b1;
    b = mir[8];
    mir[8] = b - 32'h14;
    send(3'h7, 32'h0, 3'h0);
    @(negedge core_clk);
    req_valid = 1'b0;
    chk({31'h0, busy_q}, 32'h1);
    drain();
    for (i = 0; i < 5; i++) chk(u_mem.mem[b - 4 * (i + 1)], mir[14 - i]);
    for (i = 0; i < 17; i++) rchk(i);
    for (i = 0; i < 4; i++) begin
      mk(OP_BRANCH, EA_DREG, SZ_WORD, 3'h0);
      x.cond = 1'b1;
      x.long_disp = i < 2;
      x.ext0 = i[0] ? 16'h7FFF : 16'h8000;
      x.imm8 = i[0] ? 8'h7F : 8'h80;
      send(3'h2, x.pc + 32'h2 + (i < 2 ? s16(x.ext0) : s8(x.imm8)), 3'h4);
    end
    for (i = 0; i < 4; i++) begin
      mk(OP_QADD, EA_DREG, SZ_LONG, 3'h4);
      x.imm8 = 8'(32'h09080100 >> (8 * i));
      send(3'h7, 32'h0, {2'h0, x.imm8 == 8'h0 || x.imm8 > 8'h08});
      mk(OP_QMOVE, EA_DREG, SZ_LONG, 3'h5);
      x.imm8 = 8'($urandom);
      send(3'h3, s8(x.imm8), 3'h0);
      mk(OP_ADDRDST, i == 3 ? EA_DREG : EA_AREG, eal_size_type'(i % 3), 3'h3);
      f = i == 0 || i == 3;
      send(f ? 3'h7 : 3'h3, i == 1 ? s16(x.ext0) : {x.ext0, x.ext1}, {2'h0, f});
      mk(OP_BIT, i[0] ? EA_DREG : EA_IND, SZ_BYTE, 3'h4);
      x.imm8 = 8'($urandom);
      send(3'h3, 32'h1 << (i[0] ? x.imm8[4:0] : {2'h0, x.imm8[2:0]}), 3'h0);
    end
    wreg(10, mir[10] | 32'h1);
    for (i = 0; i < 3; i++) begin
      mk(OP_EA, EA_IND, i == 2 ? SZ_BYTE : SZ_WORD, 3'h2);
      x.pc[0] = i == 0;
      send(i == 2 ? 3'h0 : 3'h7, mir[10], {1'b0, i != 2, 1'b0});
    end
    drain();
    results();
  end
endmodule

//--- verilog/eal_unit.sv
// Effective address, branch target, loop and multi-register transfer unit
// Functional notes
// - Long branch uses signed 16-bit displacement, reach -32768..+32767 bytes.
// - Loop with condition true does nothing and falls through.
// - Loop with condition false decrements data register; -1 falls through, else branches.
// - Loop target is a 16-bit displacement from the program counter.
// - Multi-register transfer order is fixed by the mask, not the listing.
// - Word loads sign-extend into register; postincrement pointer advances by 2.
// - Long predecrement stores decrement by 4 first, highest address register first.
// - Postincrement loads fill data registers, then address registers, ascending.
// - Quick add accepts immediate 1 to 8 only.
// - Address destination forms need an address register and no byte size.
// - Quick move is always long with its byte immediate sign-extended.
// - Memory compare uses postincrement on both operands.
// - Bytes may be odd; words, longs and instructions must be even.
// - Bit numbers run 7..0 in memory bytes, 31..0 in data registers.
// - Displacement mode adds sign-extended 16-bit value to full address register.
// - Indexed mode adds base, sign-extended 8-bit value and word or long index.
// - Absolute short is sign-extended 16 bits; absolute long used unchanged.
// - PC relative uses 16-bit displacement; PC indexed uses 8-bit plus index.
// - Branch targets are 8- or 16-bit PC displacements by encoding; loop targets are 16-bit only.
// - Immediate operands exist for byte, word and long.
// - Address register seven selects supervisor or user stack pointer by mode.
// - Predecrement and postincrement step by 1, 2 or 4 by size.
// - PC base for displacements is instruction address plus two.
`include "eal_params.svh"
module eal_unit (
  input  logic                  core_clk,
  input  logic                  rst_b,
  input  logic                  req_valid,
  input  eal_pkg::eal_req_type  req,
  input  logic                  wr_en,
  input  logic [4:0]            wr_idx,
  input  logic [31:0]           wr_data,
  input  logic [4:0]            rd_idx,
  input  logic                  mem_ack,
  input  logic [31:0]           mem_rdata,
  output logic                  busy_q,
  output logic                  done_q,
  output eal_pkg::eal_resp_type resp_q,
  output eal_pkg::eal_mem_type  mem_q,
  output logic [31:0]           rd_data_q
);
  import eal_pkg::*;

  logic [31:0]   regs_q [0:`EAL_NREG-1];
  eal_state_type st_q, st_d;
  logic [15:0]   mask_q;
  logic [31:0]   ptr_q;
  logic [3:0]    cur_q;
  logic [4:0]    base_q;
  eal_size_type  sz_q;
  eal_mode_type  md_q;
  logic          we_q;
  logic          sup_q;

  logic          accept;
  logic [31:0]   base, base2, idxv, idx_term, pc_base, ea_c, stp;
  logic [31:0]   br_target, dreg, dec, imm_val;
  logic          is_mem, misalign, misalign2, bad, mrt_next;
  logic [3:0]    pick;

  function automatic logic [31:0] sx8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] sx16(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction

  function automatic logic [31:0] step(input eal_size_type s);
    case (s)
      SZ_BYTE: return `EAL_STEP_B;
      SZ_WORD: return `EAL_STEP_W;
      default: return `EAL_STEP_L;
    endcase
  endfunction

  // Logical 0-7 data, 8-15 address; address seven splits into two stack pointers
  function automatic logic [4:0] phys(input logic [3:0] r, input logic s);
    if (r == `EAL_ALIAS_REG) begin
      return s ? `EAL_SSP_IDX : `EAL_USP_IDX;
    end
    return {1'b0, r};
  endfunction

  assign accept = req_valid && (st_q == ST_IDLE);

  always_comb begin
    base     = regs_q[phys({1'b1, req.reg_num}, req.sup)];
    base2    = regs_q[phys({1'b1, req.reg2}, req.sup)];
    idxv     = regs_q[phys(req.idx_reg, req.sup)];
    idx_term = req.idx_long ? idxv : sx16(idxv[15:0]);
    pc_base  = req.pc + `EAL_PC_STEP;
    stp      = step(req.size);
    case (req.mode)
      EA_IND, EA_POSTINC: ea_c = base;
      EA_PREDEC:   ea_c = base - stp;
      EA_DISP:     ea_c = base + sx16(req.ext0);
      EA_INDEX:    ea_c = base + sx8(req.ext0[7:0]) + idx_term;
      EA_ABS_S:    ea_c = sx16(req.ext0);
      EA_ABS_L:    ea_c = {req.ext0, req.ext1};
      EA_PC_DISP:  ea_c = pc_base + sx16(req.ext0);
      EA_PC_INDEX: ea_c = pc_base + sx8(req.ext0[7:0]) + idx_term;
      EA_IMM:      ea_c = pc_base;
      default:     ea_c = `EAL_REG_RST;
    endcase
    is_mem    = (req.mode != EA_DREG) && (req.mode != EA_AREG);
    misalign  = (is_mem && (req.size != SZ_BYTE) && ea_c[0]) || req.pc[0];
    misalign2 = (req.size != SZ_BYTE) && base2[0];
    // Short form takes the byte in the opcode, long form the extension word
    br_target = pc_base + (req.long_disp ? sx16(req.ext0) : sx8(req.imm8));
    dreg      = regs_q[{2'b00, req.reg_num}];
    dec       = dreg - `EAL_STEP_B;
    case (req.size)
      SZ_BYTE: imm_val = {24'h000000, req.ext0[7:0]};
      SZ_WORD: imm_val = {16'h0000, req.ext0};
      default: imm_val = {req.ext0, req.ext1};
    endcase
    case (req.op)
      OP_QADD:    bad = (req.imm8 < `EAL_QADD_MIN) || (req.imm8 > `EAL_QADD_MAX);
      OP_ADDRDST: bad = (req.size == SZ_BYTE) || (req.mode != EA_AREG);
      OP_MEMORY_COMPARE_POSTINC:    bad = (req.mode != EA_POSTINC);
      OP_MRT:     bad = (req.size == SZ_BYTE) || !is_mem || (req.mode == EA_IMM) ||
                        (req.to_mem ? (req.mode == EA_POSTINC) : (req.mode == EA_PREDEC));
      default:    bad = 1'b0;
    endcase
  end

  // Predecrement walks down from the top, all other modes walk up
  always_comb begin
    pick = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (md_q == EA_PREDEC) begin
        if (mask_q[i]) begin
          pick = 4'(i);
        end
      end else if (mask_q[15-i]) begin
        pick = 4'(15 - i);
      end
    end
  end

  assign mrt_next = accept && (req.op == OP_MRT) && !bad && !misalign;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (mrt_next) begin
          st_d = ST_XFER;
        end
      end
      ST_XFER: begin
        if (!mem_q.req && (mask_q == 16'h0000)) begin
          st_d = ST_WB;
        end
      end
      ST_WB: st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= ST_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      busy_q <= (st_d != ST_IDLE);
      done_q <= (accept && !mrt_next) || (st_q == ST_WB);
    end
  end

  // Single-cycle answers
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_q <= '0;
    end else if (accept) begin
      resp_q.ea      <= ea_c;
      resp_q.ea2     <= base2;
      resp_q.target  <= req.pc + `EAL_LOOP_LEN;
      resp_q.result  <= imm_val;
      resp_q.taken   <= 1'b0;
      resp_q.illegal <= bad;
      resp_q.fault   <= misalign || ((req.op == OP_MEMORY_COMPARE_POSTINC) && misalign2);
      case (req.op)
        OP_BRANCH: begin
          resp_q.target <= br_target;
          resp_q.taken  <= req.cond;
        end
        OP_LOOP: begin
          // Not taken keeps the fall-through address set above
          if (!req.cond && (dec != `EAL_LOOP_END)) begin
            resp_q.target <= pc_base + sx16(req.ext0);
            resp_q.taken  <= 1'b1;
          end
        end
        OP_QADD:    resp_q.result <= {24'h000000, req.imm8};
        OP_ADDRDST: resp_q.result <= (req.size == SZ_WORD) ? sx16(req.ext0) : imm_val;
        OP_QMOVE:   resp_q.result <= sx8(req.imm8);
        OP_BIT: begin
          if (req.mode == EA_DREG) begin
            resp_q.result <= `EAL_BIT_ONE << req.imm8[4:0];
          end else begin
            resp_q.result <= `EAL_BIT_ONE << req.imm8[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Multi-register transfer sequencer and memory requests
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_q  <= '0;
      mask_q <= 16'h0000;
      ptr_q  <= `EAL_REG_RST;
      cur_q  <= 4'h0;
      base_q <= 5'h00;
      sz_q   <= SZ_WORD;
      md_q   <= EA_IND;
      we_q   <= 1'b0;
      sup_q  <= 1'b0;
    end else if (mrt_next) begin
      mask_q <= req.mask;
      ptr_q  <= (req.mode == EA_PREDEC) ? base : ea_c;
      base_q <= phys({1'b1, req.reg_num}, req.sup);
      sz_q   <= req.size;
      md_q   <= req.mode;
      we_q   <= req.to_mem;
      sup_q  <= req.sup;
    end else if (st_q == ST_XFER) begin
      if (mem_q.req) begin
        if (mem_ack) begin
          mem_q.req <= 1'b0;
        end
      end else if (mask_q != 16'h0000) begin
        mem_q.req    <= 1'b1;
        mem_q.we     <= we_q;
        mem_q.size   <= sz_q;
        mem_q.wdata  <= regs_q[phys(pick, sup_q)];
        cur_q        <= pick;
        mask_q[pick] <= 1'b0;
        if (md_q == EA_PREDEC) begin
          mem_q.addr <= ptr_q - step(sz_q);
          ptr_q      <= ptr_q - step(sz_q);
        end else begin
          mem_q.addr <= ptr_q;
          ptr_q      <= ptr_q + step(sz_q);
        end
      end
    end
  end

  // Register file; internal updates follow the outside write so they win
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < `EAL_NREG; i++) begin
        regs_q[i] <= `EAL_REG_RST;
      end
      rd_data_q <= `EAL_REG_RST;
    end else begin
      rd_data_q <= (rd_idx < 5'(`EAL_NREG)) ? regs_q[rd_idx] : `EAL_REG_RST;
      if (wr_en && (wr_idx < 5'(`EAL_NREG))) begin
        regs_q[wr_idx] <= wr_data;
      end
      if (accept && !bad && !misalign) begin
        case (req.op)
          OP_EA: begin
            if (req.mode == EA_POSTINC) begin
              regs_q[phys({1'b1, req.reg_num}, req.sup)] <= base + stp;
            end else if (req.mode == EA_PREDEC) begin
              regs_q[phys({1'b1, req.reg_num}, req.sup)] <= ea_c;
            end
          end
          OP_LOOP: begin
            if (!req.cond) begin
              regs_q[{2'b00, req.reg_num}] <= dec;
            end
          end
          OP_MEMORY_COMPARE_POSTINC: begin
            if (!misalign2) begin
              // Same register for both operands steps twice
              if (req.reg_num == req.reg2) begin
                regs_q[phys({1'b1, req.reg_num}, req.sup)] <= base + stp + stp;
              end else begin
                regs_q[phys({1'b1, req.reg_num}, req.sup)] <= base + stp;
                regs_q[phys({1'b1, req.reg2}, req.sup)]    <= base2 + stp;
              end
            end
          end
          default: ;
        endcase
      end
      if ((st_q == ST_XFER) && mem_q.req && mem_ack && !mem_q.we) begin
        regs_q[phys(cur_q, sup_q)] <=
          (sz_q == SZ_WORD) ? sx16(mem_rdata[15:0]) : mem_rdata;
      end
      if ((st_q == ST_WB) && ((md_q == EA_PREDEC) || (md_q == EA_POSTINC))) begin
        regs_q[base_q] <= ptr_q;
      end
    end
  end
endmodule
